// File: design/scan_pkg.sv
// Constants shared by the serial scan engine: register indices, field positions, reset values.
// Assumes a 16-bit register port addressed by word index.
package scan_pkg;
	localparam logic [3:0]  REG_SETUP     = 4'h0;
	localparam logic [3:0]  REG_CLKDIV    = 4'h1;
	localparam logic [3:0]  REG_LFSR_EXP  = 4'h2;
	localparam logic [3:0]  REG_SEED_LO   = 4'h3;
	localparam logic [3:0]  REG_SEED_HI   = 4'h4;
	localparam logic [3:0]  REG_RESULT_LO = 4'h5;
	localparam logic [3:0]  REG_RESULT_HI = 4'h6;
	localparam logic [3:0]  REG_STATUS    = 4'h7;
	localparam logic [3:0]  REG_CAPTURE   = 4'h8;
	localparam int          SETUP_TAP_RESET_BIT = 5;
	localparam logic [15:0] SETUP_RESET   = 16'h0000;
	localparam logic [15:0] CLKDIV_RESET  = 16'h0004;
	localparam logic [2:0]  LFSR_EXP_RESET = 3'h0;
	localparam logic [31:0] SEED_RESET    = 32'h0000_0000;
	localparam int          STAT_CMP_BIT  = 15;
	localparam int          STAT_TAP_LSB  = 4;
	localparam int          STAT_DR_BIT   = 2;
	localparam int          STAT_IR_BIT   = 1;
	localparam int          STAT_BUSY_BIT = 0;
	localparam logic [1:0]  LOOP_NORMAL   = 2'h0;
	localparam logic [1:0]  LOOP_TMS      = 2'h1;
	localparam logic [1:0]  LOOP_TDO      = 2'h2;
	localparam logic [3:0]  TMS_SKIP_BASE = 4'h7;
	localparam int          LOOP_BIT      = 7;
	localparam int          EXIT_BIT      = 8;
	localparam logic [3:0]  POST_LSB      = 4'h9;
	localparam int          IR_PAD_PER_LEVEL = 8;
	localparam logic [2:0]  TLR_ONES      = 3'h5;
	localparam logic [31:0] POLY0 = 32'h8000_0057;
	localparam logic [31:0] POLY1 = 32'h8020_0003;
	localparam logic [31:0] POLY2 = 32'h8000_0062;
	localparam logic [31:0] POLY3 = 32'h0400_0007;
	localparam logic [31:0] POLY4 = 32'h04C1_1DB7;
	localparam logic [3:0]  TAP_TLR  = 4'h0;
	localparam logic [3:0]  TAP_RTI  = 4'h1;
	localparam logic [3:0]  TAP_SELDR = 4'h2;
	localparam logic [3:0]  TAP_CAPDR = 4'h3;
	localparam logic [3:0]  TAP_SHDR = 4'h4;
	localparam logic [3:0]  TAP_EX1DR = 4'h5;
	localparam logic [3:0]  TAP_PADR = 4'h6;
	localparam logic [3:0]  TAP_EX2DR = 4'h7;
	localparam logic [3:0]  TAP_UPDR = 4'h8;
	localparam logic [3:0]  TAP_SELIR = 4'h9;
	localparam logic [3:0]  TAP_CAPIR = 4'hA;
	localparam logic [3:0]  TAP_SHIR = 4'hB;
	localparam logic [3:0]  TAP_EX1IR = 4'hC;
	localparam logic [3:0]  TAP_PAIR = 4'hD;
	localparam logic [3:0]  TAP_EX2IR = 4'hE;
	localparam logic [3:0]  TAP_UPIR = 4'hF;
endpackage

// File: design/scan_shift_compare_engine.sv
// Serial scan engine: scan clock divider, tap tracker, shifters, signature register and comparator.
// Assumes a sequence controller that starts vectors and supplies outgoing, expected and mask words.
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
module scan_shift_compare_engine #(
	parameter int DATA_LEN_W = 16,
	parameter int LEVEL_W    = 3
) (
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	input  wire logic [3:0]            reg_addr,
	input  wire logic [15:0]           reg_wdata,
	input  wire logic                  reg_wr,
	input  wire logic                  reg_rd,
	output logic      [15:0]           reg_rdata,
	input  wire logic                  on_the_fly_load_mode,
	input  wire logic                  seq_run_start,
	input  wire logic                  vec_start,
	input  wire logic [15:0]           vec_macro,
	input  wire logic [2:0]            vec_pre_count,
	input  wire logic [2:0]            vec_post_count,
	input  wire logic [DATA_LEN_W-1:0] vec_data_len,
	input  wire logic                  vec_capture,
	input  wire logic                  vec_compare,
	input  wire logic                  vec_use_mask,
	input  wire logic                  vec_preloaded,
	input  wire logic                  bridge_active,
	input  wire logic [LEVEL_W-1:0]    bridge_levels,
	input  wire logic [31:0]           tdo_word,
	input  wire logic [31:0]           exp_word,
	input  wire logic [31:0]           mask_word,
	input  wire logic                  tdo_word_valid,
	output logic                       tdo_word_take,
	output logic      [31:0]           cap_word,
	output logic                       cap_word_valid,
	output logic                       vec_busy,
	output logic                       vec_done,
	output logic                       scan_clock_out,
	output logic                       scan_mode_select_out,
	output logic                       scan_data_out,
	input  wire logic                  scan_data_in,
	output logic                       instruction_shift_state,
	output logic                       data_shift_state,
	output logic      [15:0]           tap_state
);
	typedef enum logic [2:0] {S_IDLE, S_PRE, S_LEAD, S_DATA, S_TRAIL, S_POST, S_FLUSH} phase_e;

	function automatic logic [7:0] divisor(input logic [15:0] r);
		logic [7:0] d;
		d = 8'h02;
		for (int i = 1; i <= 7; i++) begin
			if (r[i]) begin
				d = 8'(1 << i);
			end
		end
		return d;
	endfunction

	function automatic logic [3:0] tap_next(input logic [3:0] s, input logic m);
		case (s)
			scan_pkg::TAP_TLR:   tap_next = m ? scan_pkg::TAP_TLR : scan_pkg::TAP_RTI;
			scan_pkg::TAP_RTI:   tap_next = m ? scan_pkg::TAP_SELDR : scan_pkg::TAP_RTI;
			scan_pkg::TAP_SELDR: tap_next = m ? scan_pkg::TAP_SELIR : scan_pkg::TAP_CAPDR;
			scan_pkg::TAP_CAPDR: tap_next = m ? scan_pkg::TAP_EX1DR : scan_pkg::TAP_SHDR;
			scan_pkg::TAP_SHDR:  tap_next = m ? scan_pkg::TAP_EX1DR : scan_pkg::TAP_SHDR;
			scan_pkg::TAP_EX1DR: tap_next = m ? scan_pkg::TAP_UPDR : scan_pkg::TAP_PADR;
			scan_pkg::TAP_PADR:  tap_next = m ? scan_pkg::TAP_EX2DR : scan_pkg::TAP_PADR;
			scan_pkg::TAP_EX2DR: tap_next = m ? scan_pkg::TAP_UPDR : scan_pkg::TAP_SHDR;
			scan_pkg::TAP_UPDR:  tap_next = m ? scan_pkg::TAP_SELDR : scan_pkg::TAP_RTI;
			scan_pkg::TAP_SELIR: tap_next = m ? scan_pkg::TAP_TLR : scan_pkg::TAP_CAPIR;
			scan_pkg::TAP_CAPIR: tap_next = m ? scan_pkg::TAP_EX1IR : scan_pkg::TAP_SHIR;
			scan_pkg::TAP_SHIR:  tap_next = m ? scan_pkg::TAP_EX1IR : scan_pkg::TAP_SHIR;
			scan_pkg::TAP_EX1IR: tap_next = m ? scan_pkg::TAP_UPIR : scan_pkg::TAP_PAIR;
			scan_pkg::TAP_PAIR:  tap_next = m ? scan_pkg::TAP_EX2IR : scan_pkg::TAP_PAIR;
			scan_pkg::TAP_EX2IR: tap_next = m ? scan_pkg::TAP_UPIR : scan_pkg::TAP_SHIR;
			default:             tap_next = m ? scan_pkg::TAP_SELDR : scan_pkg::TAP_RTI;
		endcase
	endfunction

	function automatic logic [31:0] poly_of(input logic [2:0] code);
		case (code)
			3'h1:    poly_of = scan_pkg::POLY1;
			3'h2:    poly_of = scan_pkg::POLY2;
			3'h3:    poly_of = scan_pkg::POLY3;
			3'h4:    poly_of = scan_pkg::POLY4;
			default: poly_of = scan_pkg::POLY0;
		endcase
	endfunction

	phase_e                st_ff;
	logic [15:0]           setup_ff;
	logic [15:0]           clkdiv_ff;
	logic [2:0]            exp_code_ff;
	logic [31:0]           seed_ff;
	logic [31:0]           result_ff;
	logic [7:0]            cnt_ff;
	logic                  tck_on_ff;
	logic                  cap_on_ff;
	logic [15:0]           macro_ff;
	logic [15:0]           tms_sh_ff;
	logic [31:0]           tdo_sh_ff;
	logic [31:0]           exp_sh_ff;
	logic [31:0]           mask_sh_ff;
	logic                  exp_bit_ff;
	logic                  mask_bit_ff;
	logic [4:0]            word_idx_ff;
	logic [DATA_LEN_W-1:0] rem_ff;
	logic [DATA_LEN_W-1:0] data_len_ff;
	logic [DATA_LEN_W-1:0] trail_len_ff;
	logic [2:0]            post_ff;
	logic                  capture_ff;
	logic                  cmp_act_ff;
	logic                  use_mask_ff;
	logic                  tms_out_ff;
	logic                  tdo_out_ff;
	logic                  tck_ff;
	logic                  done_ff;
	logic [3:0]            tap_idx_ff;
	logic [2:0]            ones_ff;
	logic                  din_meta_ff;
	logic                  din_sync_ff;
	logic [31:0]           cap_sh_ff;
	logic [4:0]            cap_cnt_ff;
	logic [31:0]           cap_word_ff;
	logic                  cap_valid_ff;
	logic [31:0]           lfsr_ff;
	logic                  imm_ff;
	logic                  sticky_ff;
	logic                  cmp_res_ff;
	logic [15:0]           rdata_ff;
	logic [15:0]           cap_hi_ff;
	logic                  cap_hi_pend_ff;

	logic [7:0]            div;
	logic [7:0]            half;
	logic                  stall;
	logic                  running;
	logic                  so;
	logic                  si;
	logic                  last_body;
	logic [3:0]            entry_idx;
	logic [DATA_LEN_W-1:0] lead_len;
	logic [DATA_LEN_W-1:0] trail_len;
	logic                  bit_in;
	logic                  match;
	logic                  tap_reset_req;
	logic [15:0]           status;

	assign div = divisor(clkdiv_ff);
	assign half = {1'b0, div[7:1]};
	assign stall = on_the_fly_load_mode && st_ff == S_DATA && word_idx_ff == 5'h00
		&& !tdo_word_valid && cnt_ff == 8'h00;
	assign running = st_ff != S_IDLE && !stall;
	assign so = running && cnt_ff == div - 8'h01;
	assign si = running && tck_on_ff && cnt_ff == half - 8'h01;
	assign last_body = rem_ff == DATA_LEN_W'(1)
		&& (st_ff == S_TRAIL || (st_ff == S_DATA && trail_len_ff == '0));
	assign entry_idx = rem_ff != '0 ? tap_next(tap_idx_ff, tms_sh_ff[0]) : tap_idx_ff;
	// Pads are sized from the state the target will be in when the body starts.
	assign lead_len = (bridge_active && (entry_idx == scan_pkg::TAP_SHIR || entry_idx == scan_pkg::TAP_SHDR))
		? DATA_LEN_W'(bridge_levels) : '0;
	assign trail_len = !bridge_active ? '0
		: entry_idx == scan_pkg::TAP_SHIR ? DATA_LEN_W'(bridge_levels * scan_pkg::IR_PAD_PER_LEVEL)
		: entry_idx == scan_pkg::TAP_SHDR ? DATA_LEN_W'(bridge_levels) : '0;
	assign tap_reset_req = reg_wr && reg_addr == scan_pkg::REG_SETUP
		&& reg_wdata[scan_pkg::SETUP_TAP_RESET_BIT];
	assign match = bit_in == exp_bit_ff || (use_mask_ff && mask_bit_ff);
	assign tdo_word_take = so && st_ff == S_DATA && word_idx_ff == 5'h00;

	always_comb begin
		case (setup_ff[1:0])
			scan_pkg::LOOP_TMS: bit_in = tms_out_ff;
			scan_pkg::LOOP_TDO: bit_in = tdo_out_ff;
			default:            bit_in = din_sync_ff;
		endcase
	end

	always_ff @(posedge clk) begin
		din_meta_ff <= scan_data_in;
		din_sync_ff <= din_meta_ff;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			setup_ff <= scan_pkg::SETUP_RESET;
			clkdiv_ff <= scan_pkg::CLKDIV_RESET;
			exp_code_ff <= scan_pkg::LFSR_EXP_RESET;
			seed_ff <= scan_pkg::SEED_RESET;
		end else if (reg_wr) begin
			case (reg_addr)
				scan_pkg::REG_SETUP:    setup_ff <= reg_wdata;
				scan_pkg::REG_CLKDIV:   clkdiv_ff <= reg_wdata;
				scan_pkg::REG_LFSR_EXP: exp_code_ff <= reg_wdata[2:0];
				scan_pkg::REG_SEED_LO:  seed_ff[15:0] <= reg_wdata;
				scan_pkg::REG_SEED_HI:  seed_ff[31:16] <= reg_wdata;
				default: begin
				end
			endcase
		end
	end

	// Clock pulse counter; it holds at zero while gated, and running going low keeps the scan clock low.
	always_ff @(posedge clk) begin
		if (!rst_b || st_ff == S_IDLE || so) begin
			cnt_ff <= 8'h00;
		end else if (!stall) begin
			cnt_ff <= cnt_ff + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			tck_ff <= 1'b0;
		end else begin
			tck_ff <= tck_on_ff && running && cnt_ff >= half - 8'h01 && !so;
		end
	end

	// Phase sequencing; outputs change only on a shift-out strobe, so they hold while gated.
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_ff <= S_IDLE;
			rem_ff <= '0;
			data_len_ff <= '0;
			trail_len_ff <= '0;
			post_ff <= 3'h0;
			macro_ff <= 16'h0000;
			tms_sh_ff <= 16'h0000;
			tdo_sh_ff <= 32'h0000_0000;
			exp_sh_ff <= 32'h0000_0000;
			mask_sh_ff <= 32'h0000_0000;
			exp_bit_ff <= 1'b0;
			mask_bit_ff <= 1'b0;
			word_idx_ff <= 5'h00;
			capture_ff <= 1'b0;
			cmp_act_ff <= 1'b0;
			use_mask_ff <= 1'b0;
			tms_out_ff <= 1'b1;
			tdo_out_ff <= 1'b1;
			tck_on_ff <= 1'b0;
			cap_on_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			if (st_ff == S_IDLE && vec_start) begin
				st_ff <= S_PRE;
				rem_ff <= DATA_LEN_W'(vec_pre_count);
				macro_ff <= vec_macro;
				tms_sh_ff <= vec_macro >> (scan_pkg::TMS_SKIP_BASE - {1'b0, vec_pre_count});
				data_len_ff <= vec_data_len;
				post_ff <= vec_post_count;
				word_idx_ff <= 5'h00;
				capture_ff <= vec_capture;
				cmp_act_ff <= (vec_compare || vec_use_mask) && vec_preloaded && !on_the_fly_load_mode;
				use_mask_ff <= vec_use_mask;
			end else if (so) begin
				tck_on_ff <= 1'b1;
				cap_on_ff <= 1'b0;
				case (st_ff)
					S_PRE: begin
						if (rem_ff == '0) begin
							tck_on_ff <= 1'b0;
						end else begin
							tms_out_ff <= tms_sh_ff[0];
							tms_sh_ff <= tms_sh_ff >> 1;
						end
						if (rem_ff <= DATA_LEN_W'(1)) begin
							trail_len_ff <= trail_len;
							st_ff <= lead_len != '0 ? S_LEAD : S_DATA;
							rem_ff <= lead_len != '0 ? lead_len : data_len_ff;
						end else begin
							rem_ff <= rem_ff - DATA_LEN_W'(1);
						end
					end
					S_LEAD: begin
						tms_out_ff <= macro_ff[scan_pkg::LOOP_BIT];
						tdo_out_ff <= 1'b1;
						rem_ff <= rem_ff == DATA_LEN_W'(1) ? data_len_ff : rem_ff - DATA_LEN_W'(1);
						if (rem_ff == DATA_LEN_W'(1)) begin
							st_ff <= S_DATA;
						end
					end
					S_DATA, S_TRAIL: begin
						tms_out_ff <= last_body ? macro_ff[scan_pkg::EXIT_BIT] : macro_ff[scan_pkg::LOOP_BIT];
						if (st_ff == S_TRAIL) begin
							tdo_out_ff <= 1'b1;
						end else begin
							cap_on_ff <= capture_ff;
							word_idx_ff <= word_idx_ff + 5'h01;
							if (word_idx_ff == 5'h00) begin
								tdo_out_ff <= tdo_word[0];
								tdo_sh_ff <= tdo_word >> 1;
								exp_bit_ff <= exp_word[0];
								exp_sh_ff <= exp_word >> 1;
								mask_bit_ff <= mask_word[0];
								mask_sh_ff <= mask_word >> 1;
							end else begin
								tdo_out_ff <= tdo_sh_ff[0];
								tdo_sh_ff <= tdo_sh_ff >> 1;
								exp_bit_ff <= exp_sh_ff[0];
								exp_sh_ff <= exp_sh_ff >> 1;
								mask_bit_ff <= mask_sh_ff[0];
								mask_sh_ff <= mask_sh_ff >> 1;
							end
						end
						if (rem_ff != DATA_LEN_W'(1)) begin
							rem_ff <= rem_ff - DATA_LEN_W'(1);
						end else if (st_ff == S_DATA && trail_len_ff != '0) begin
							st_ff <= S_TRAIL;
							rem_ff <= trail_len_ff;
						end else begin
							st_ff <= post_ff != 3'h0 ? S_POST : S_FLUSH;
							rem_ff <= DATA_LEN_W'(post_ff);
							tms_sh_ff <= macro_ff >> scan_pkg::POST_LSB;
						end
					end
					S_POST: begin
						tms_out_ff <= tms_sh_ff[0];
						tms_sh_ff <= tms_sh_ff >> 1;
						rem_ff <= rem_ff - DATA_LEN_W'(1);
						if (rem_ff == DATA_LEN_W'(1)) begin
							st_ff <= S_FLUSH;
						end
					end
					default: begin
						tck_on_ff <= 1'b0;
						st_ff <= S_IDLE;
						done_ff <= 1'b1;
					end
				endcase
			end
		end
	end

	// Tap tracker advances at each rising scan clock edge with the level then driven.
	always_ff @(posedge clk) begin
		if (!rst_b || tap_reset_req) begin
			tap_idx_ff <= scan_pkg::TAP_TLR;
			ones_ff <= 3'h0;
		end else if (si) begin
			ones_ff <= tms_out_ff ? ones_ff + 3'h1 : 3'h0;
			if (tms_out_ff && ones_ff + 3'h1 >= scan_pkg::TLR_ONES) begin
				tap_idx_ff <= scan_pkg::TAP_TLR;
				ones_ff <= 3'h0;
			end else begin
				tap_idx_ff <= tap_next(tap_idx_ff, tms_out_ff);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cap_sh_ff <= 32'h0000_0000;
			cap_cnt_ff <= 5'h00;
			cap_word_ff <= 32'h0000_0000;
			cap_valid_ff <= 1'b0;
		end else begin
			cap_valid_ff <= 1'b0;
			if (si && cap_on_ff) begin
				cap_sh_ff <= {bit_in, cap_sh_ff[31:1]};
				cap_cnt_ff <= cap_cnt_ff + 5'h01;
				if (cap_cnt_ff == 5'h1F) begin
					cap_word_ff <= {bit_in, cap_sh_ff[31:1]};
					cap_valid_ff <= 1'b1;
				end
			end else if (so && st_ff == S_FLUSH && cap_cnt_ff != 5'h00) begin
				// A short last word is right-aligned so its first bit lands in bit 0.
				cap_word_ff <= cap_sh_ff >> (6'h20 - {1'b0, cap_cnt_ff});
				cap_valid_ff <= 1'b1;
				cap_cnt_ff <= 5'h00;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			lfsr_ff <= scan_pkg::SEED_RESET;
			result_ff <= scan_pkg::SEED_RESET;
		end else if (st_ff == S_IDLE && vec_start) begin
			lfsr_ff <= seed_ff;
		end else if (si && cap_on_ff) begin
			lfsr_ff <= {lfsr_ff[30:0], 1'b0} ^ ((lfsr_ff[31] ^ bit_in) ? poly_of(exp_code_ff) : 32'h0000_0000);
		end else if (so && st_ff == S_FLUSH) begin
			result_ff <= lfsr_ff;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b || seq_run_start) begin
			imm_ff <= 1'b0;
			sticky_ff <= 1'b1;
			cmp_res_ff <= 1'b0;
		end else if (st_ff == S_IDLE && vec_start) begin
			sticky_ff <= 1'b1;
		end else if (si && cap_on_ff && cmp_act_ff) begin
			imm_ff <= match;
			if (!match) begin
				sticky_ff <= 1'b0;
			end
		end else if (so && st_ff == S_FLUSH && cmp_act_ff) begin
			cmp_res_ff <= sticky_ff;
		end
	end

	always_comb begin
		status = 16'h0000;
		status[scan_pkg::STAT_CMP_BIT] = cmp_res_ff;
		status[scan_pkg::STAT_TAP_LSB +: 4] = tap_idx_ff;
		status[scan_pkg::STAT_DR_BIT] = data_shift_state;
		status[scan_pkg::STAT_IR_BIT] = instruction_shift_state;
		status[scan_pkg::STAT_BUSY_BIT] = vec_busy;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rdata_ff <= 16'h0000;
			cap_hi_ff <= 16'h0000;
			cap_hi_pend_ff <= 1'b0;
		end else if (reg_rd) begin
			case (reg_addr)
				scan_pkg::REG_SETUP:     rdata_ff <= setup_ff;
				scan_pkg::REG_CLKDIV:    rdata_ff <= clkdiv_ff;
				scan_pkg::REG_LFSR_EXP:  rdata_ff <= {13'h0000, exp_code_ff};
				scan_pkg::REG_SEED_LO:   rdata_ff <= seed_ff[15:0];
				scan_pkg::REG_SEED_HI:   rdata_ff <= seed_ff[31:16];
				scan_pkg::REG_RESULT_LO: rdata_ff <= result_ff[15:0];
				scan_pkg::REG_RESULT_HI: rdata_ff <= result_ff[31:16];
				scan_pkg::REG_STATUS:    rdata_ff <= status;
				scan_pkg::REG_CAPTURE: begin
					// The high half is frozen at the first read so a new word cannot tear the pair.
					rdata_ff <= cap_hi_pend_ff ? cap_hi_ff : cap_word_ff[15:0];
					cap_hi_ff <= cap_word_ff[31:16];
					cap_hi_pend_ff <= !cap_hi_pend_ff;
				end
				default:                 rdata_ff <= 16'h0000;
			endcase
		end else begin
			rdata_ff <= 16'h0000;
		end
	end

	assign reg_rdata = rdata_ff;
	assign cap_word = cap_word_ff;
	assign cap_word_valid = cap_valid_ff;
	assign vec_busy = st_ff != S_IDLE;
	assign vec_done = done_ff;
	assign scan_clock_out = tck_ff;
	assign scan_mode_select_out = tms_out_ff;
	assign scan_data_out = tdo_out_ff;
	assign tap_state = 16'h0001 << tap_idx_ff;
	assign instruction_shift_state = tap_idx_ff == scan_pkg::TAP_SHIR;
	assign data_shift_state = tap_idx_ff == scan_pkg::TAP_SHDR;
endmodule // scan_shift_compare_engine

// File: bench/scan_sva.sv
// Checker on the scan engine ports.
// Assumes it is bound onto every scan engine instance.
`timescale 1ns/10ps
module scan_sva (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic [3:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic        tdo_word_valid,
	input wire logic        tdo_word_take,
	input wire logic        cap_word_valid,
	input wire logic        vec_busy,
	input wire logic        vec_done,
	input wire logic        instruction_shift_state,
	input wire logic        data_shift_state,
	input wire logic [15:0] tap_state,
	input wire logic        scan_clock_out,
	input wire logic        scan_mode_select_out,
	input wire logic        scan_data_out
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_tap_one_hot: assert property ($onehot(tap_state)) else $error("tracker not one-hot");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("stray read data");
	a_tracker_reset: assert property (reg_wr && reg_addr == scan_pkg::REG_SETUP
		&& reg_wdata[scan_pkg::SETUP_TAP_RESET_BIT] |=> tap_state == 16'h0001) else $error("no tracker reset");
	a_shift_flags: assert property (instruction_shift_state == tap_state[11]
		&& data_shift_state == tap_state[4]) else $error("shift flags wrong");
	a_take_gated: assert property (tdo_word_take |-> tdo_word_valid && vec_busy) else $error("take without word");
	a_take_single: assert property (tdo_word_take |=> !tdo_word_take) else $error("word taken twice");
	a_done_pulse: assert property (vec_done |-> $past(vec_busy) ##1 !vec_done) else $error("bad done");
	a_cap_pulse: assert property (cap_word_valid |=> !cap_word_valid) else $error("capture not a pulse");
	a_out_clk_low: assert property ($changed(scan_data_out) || $changed(scan_mode_select_out)
		|-> !scan_clock_out) else $error("scan output moved with scan clock high");
endmodule // scan_sva
bind scan_shift_compare_engine scan_sva sva_u (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.tdo_word_valid, .tdo_word_take, .cap_word_valid, .vec_busy, .vec_done, .instruction_shift_state,
	.data_shift_state, .tap_state, .scan_clock_out, .scan_mode_select_out, .scan_data_out);

// File: bench/scan_target.sv
// Target chain model: a single bypass stage.
// Assumes the engine's scan clock and data pins.
`timescale 1ns/10ps
module scan_target (
	input  wire logic scan_clock_out,
	input  wire logic scan_data_out,
	output logic      scan_data_in
);
	logic bypass_ff = 1'b1;
	initial scan_data_in = 1'b1;
	// Capture on the rising scan edge, launch on the falling one, as a real chain does.
	always @(posedge scan_clock_out) bypass_ff <= scan_data_out;
	always @(negedge scan_clock_out) scan_data_in <= bypass_ff;
endmodule // scan_target

// File: bench/tb.sv
// Testbench: register port, all divisors, gated loop-back vectors.
// Assumes the engine package and the target model.
`timescale 1ns/10ps
module tb;
	logic        clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_ff = 1'b0, sclk_q = 1'b0;
	logic        on_the_fly_load_mode = 1'b0, seq_run_start = 1'b0, vec_start = 1'b0, tdo_word_valid = 1'b0;
	logic        vec_capture = 1'b1, vec_compare = 1'b0, vec_use_mask = 1'b0, vec_preloaded = 1'b0;
	logic        bridge_active = 1'b0, cmp_exp = 1'b0;
	logic [2:0]  bridge_levels = 3'h0, vec_pre_count = 3'h0, vec_post_count = 3'h0;
	logic [3:0]  reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, vec_macro = 16'h0000, vec_data_len = 16'h0020, reg_rdata, tap_state;
	logic [31:0] tdo_word = 32'h0000_0000, exp_word = 32'h0000_0000, mask_word = 32'h0000_0000, cap_word;
	logic [31:0] lfsr = 32'h0000_a5b4;
	logic        tdo_word_take, cap_word_valid, vec_busy, vec_done, scan_clock_out, scan_mode_select_out;
	logic        scan_data_out, scan_data_in, instruction_shift_state, data_shift_state;
	logic [31:0] rq[$], cq[$];
	int          fail_count = 0, n_checks = 0, cycles = 0, last_rise = 0, div = 4;
	scan_shift_compare_engine dut_u (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.on_the_fly_load_mode, .seq_run_start, .vec_start, .vec_macro, .vec_pre_count, .vec_post_count,
		.vec_data_len, .vec_capture, .vec_compare, .vec_use_mask, .vec_preloaded, .bridge_active,
		.bridge_levels, .tdo_word, .exp_word, .mask_word, .tdo_word_valid, .tdo_word_take, .cap_word,
		.cap_word_valid, .vec_busy, .vec_done, .scan_clock_out, .scan_mode_select_out, .scan_data_out,
		.scan_data_in, .instruction_shift_state, .data_shift_state, .tap_state);
	scan_target target_u (.scan_clock_out, .scan_data_out, .scan_data_in);
	always #2.5 clk = ~clk;
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Each access takes two cycles so no strobe is assigned twice in one step.
	task automatic access(input logic wr, input logic [3:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= wr;
		reg_rd <= !wr;
		if (!wr)
			rq.push_back({16'h0000, d});
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(posedge clk);
	endtask
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic vec(input logic otf, input logic [15:0] len);
		logic [31:0] msk, ex, sig;
		lfsr = lfsr_next(lfsr);
		msk = 32'hffff_ffff >> (32 - len);
		ex = lfsr ^ (lfsr[3] ? 32'h0000_0000 : 32'h0000_0001 << lfsr[8:4]);
		sig = 32'h2468_1357;
		for (int i = 0; i < len; i++)
			sig = {sig[30:0], 1'b0} ^ ((sig[31] ^ lfsr[i]) ? scan_pkg::POLY4 : 32'h0000_0000);
		if ((lfsr[2] || lfsr[1]) && lfsr[0] && !otf)
			cmp_exp = ((ex ^ lfsr) & msk & (lfsr[1] ? ~lfsr : 32'hffff_ffff)) == 32'h0000_0000;
		tdo_word <= lfsr;
		exp_word <= ex;
		mask_word <= lfsr;
		{vec_compare, vec_use_mask, vec_preloaded} <= lfsr[2:0];
		// Bit 7 high keeps every body bit but the last high, so the tracker ends in a known state.
		vec_macro <= lfsr[31:16] | 16'h0080;
		vec_data_len <= len;
		on_the_fly_load_mode <= otf;
		cq.push_back(lfsr & msk);
		vec_start <= 1'b1;
		@(posedge clk);
		vec_start <= 1'b0;
		repeat (otf ? 40 : 0) @(posedge clk);
		tdo_word_valid <= 1'b1;
		for (int i = 0; i < 9000 && vec_done !== 1'b1; i++) @(negedge clk);
		check("done", vec_done, 1'b1);
		@(posedge clk);
		access(1'b0, scan_pkg::REG_CAPTURE, msk[15:0] & lfsr[15:0]);
		access(1'b0, scan_pkg::REG_CAPTURE, msk[31:16] & lfsr[31:16]);
		access(1'b0, scan_pkg::REG_RESULT_LO, sig[15:0]);
		access(1'b0, scan_pkg::REG_RESULT_HI, sig[31:16]);
		access(1'b0, scan_pkg::REG_STATUS, {cmp_exp, 10'h000, !lfsr[24], 4'h0});
		$display("vector test done, divisor %0d", div);
	endtask
	always @(posedge clk) begin
		cycles++;
		rd_ff <= reg_rd;
		sclk_q <= scan_clock_out;
		if (tdo_word_take)
			tdo_word_valid <= 1'b0;
		if (rd_ff)
			check("rdata", {16'h0000, reg_rdata}, rq.pop_front());
		if (cap_word_valid)
			check("cap_word", cap_word, cq.size() ? cq.pop_front() : 32'hdead_beef);
		if (!vec_busy || on_the_fly_load_mode)
			last_rise <= 0;
		else if (scan_clock_out && !sclk_q) begin
			if (last_rise > 0)
				check("period", 32'(cycles - last_rise), 32'(div));
			last_rise <= cycles;
		end
		if (cycles == 60000) begin
			fail_count++;
			finish_test();
		end
	end
	initial begin
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		access(1'b0, scan_pkg::REG_CLKDIV, scan_pkg::CLKDIV_RESET);
		access(1'b0, scan_pkg::REG_STATUS, 16'h0000);
		access(1'b0, 4'hF, 16'h0000);
		access(1'b1, scan_pkg::REG_LFSR_EXP, 16'h0004);
		access(1'b1, scan_pkg::REG_SEED_LO, 16'h1357);
		access(1'b1, scan_pkg::REG_SEED_HI, 16'h2468);
		access(1'b0, scan_pkg::REG_SEED_HI, 16'h2468);
		access(1'b1, scan_pkg::REG_SETUP, {14'h0000, scan_pkg::LOOP_TDO});
		seq_run_start <= 1'b1;
		@(posedge clk);
		seq_run_start <= 1'b0;
		for (int k = 1; k < 8; k++) begin
			access(1'b1, scan_pkg::REG_CLKDIV, 16'hff01 | (16'h0001 << k));
			div = 1 << k;
			vec(k[0], k == 2 ? 16'h0014 : 16'h0020);
		end
		access(1'b1, scan_pkg::REG_SETUP, 16'h0022);
		check("tap_state", {16'h0000, tap_state}, 32'h0000_0001);
		finish_test();
	end
endmodule // tb
